/* File: inc/dss_map.svh */
// Constants for the DRAM strobe sequencer
`ifndef DSS_MAP_SVH
`define DSS_MAP_SVH
`define DSS_ADDR_W 8
`define DSS_CLK_NS 40
`define DSS_ROW_HOLD_NS 30
`define DSS_EARLY_NS 2
`define DSS_LATE_NS 20
`define DSS_REF_CLKS 3
`define DSS_REF_ROW_RST 8'h00
`define DSS_RAS_IDLE 2'h3
`endif

/* File: inc/dss_pkg.sv */
// Types shared by the DRAM strobe sequencer
`include "dss_map.svh"
package dss_pkg;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_ROW   = 6'h02,
      ST_COL   = 6'h04,
      ST_TAIL  = 6'h08,
      ST_REF   = 6'h10,
      ST_GRANT = 6'h20
   } dss_state_type;

   typedef struct packed {
      logic ale;
      logic rd_n;
      logic wr_n;
      logic cs_n;
      logic bank;
      logic ref_n;
      logic strap;
      logic [`DSS_ADDR_W-1:0] row;
      logic [`DSS_ADDR_W-1:0] col;
   } dss_pins_type;

   typedef struct packed {
      logic bank;
      logic [`DSS_ADDR_W-1:0] row;
      logic [`DSS_ADDR_W-1:0] col;
   } dss_req_type;
endpackage

/* File: design/dss_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dss_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_stable
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] stable_reg;

   initial begin
      if (W < 1) begin
         $error("dss_sync: W must be at least 1");
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
      end else if (i_clk_en) begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A bit moves only once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         stable_reg <= INIT;
      end else if (i_clk_en) begin
         stable_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (stable_reg & (s2_reg ^ s3_reg));
      end
   end

   assign o_stable = stable_reg;
endmodule
`default_nettype wire

/* File: design/dss_strobe_sequencer.sv */
// DRAM strobe and address-multiplex sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dss_map.svh"
module dss_strobe_sequencer #(
   parameter int REF_CLKS = `DSS_REF_CLKS
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_ale,
   input wire logic i_read_access_strobe_n,
   input wire logic i_write_access_strobe_n,
   input wire logic i_chip_select_n,
   input wire logic i_row_bank_select,
   input wire logic [`DSS_ADDR_W-1:0] i_row_addr_in,
   input wire logic [`DSS_ADDR_W-1:0] i_col_addr_in,
   input wire logic i_refresh_request_n,
   input wire logic i_wait_state_strap,
   output logic [1:0] o_ras_n,
   output logic o_cas_n,
   output logic [`DSS_ADDR_W-1:0] o_mem_addr_out,
   output logic o_ready
);
   localparam int HOLD_CALC = (`DSS_ROW_HOLD_NS + `DSS_CLK_NS - 1) / `DSS_CLK_NS;
   localparam int HOLD_CYC = (HOLD_CALC < 1) ? 1 : HOLD_CALC;
   localparam int REF_LOW = REF_CLKS - 2;
   localparam logic [1:0] HOLD_LD = 2'(HOLD_CYC);
   localparam logic [1:0] REF_LOW_C = 2'(REF_LOW);

   initial begin
      if (REF_CLKS != 3 && REF_CLKS != 4) begin
         $error("dss_strobe_sequencer: REF_CLKS must be 3 or 4");
      end
      if (HOLD_CYC > 3) begin
         $error("dss_strobe_sequencer: row hold count too wide");
      end
   end

   dss_pkg::dss_pins_type pins_raw;
   dss_pkg::dss_pins_type pins;
   dss_pkg::dss_state_type state_reg;
   dss_pkg::dss_req_type req_reg;
   logic [1:0] ras_n_reg;
   logic cas_n_reg;
   logic [`DSS_ADDR_W-1:0] addr_reg;
   logic ready_reg;
   logic [1:0] hold_reg;
   logic [1:0] ref_cnt_reg;
   logic early_reg;
   logic grant_reg;
   logic pend_reg;
   logic [`DSS_ADDR_W-1:0] ref_row_reg;
   logic ale_prev_reg;
   logic acx_prev_reg;
   logic ref_prev_reg;
   logic acx_n;
   logic ale_fall;
   logic ale_rise;
   logic acx_rise;
   logic ref_go;
   logic ref_done;
   logic [1:0] bank_ras;

   assign pins_raw = '{ale: i_ale, rd_n: i_read_access_strobe_n,
                       wr_n: i_write_access_strobe_n, cs_n: i_chip_select_n,
                       bank: i_row_bank_select, ref_n: i_refresh_request_n,
                       strap: i_wait_state_strap, row: i_row_addr_in,
                       col: i_col_addr_in};

   // Idle pins: latch high, strobes, select and request inactive
   dss_sync #(
      .W($bits(dss_pkg::dss_pins_type)),
      .INIT({7'h7A, 16'h0000})
   ) u_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en),
      .i_async(pins_raw),
      .o_stable(pins)
   );

   assign acx_n = pins.rd_n & pins.wr_n;
   assign ale_fall = ale_prev_reg & ~pins.ale;
   assign ale_rise = ~ale_prev_reg & pins.ale;
   assign acx_rise = ~acx_prev_reg & acx_n;
   assign ref_go = pend_reg & pins.ale;
   assign ref_done = (state_reg == dss_pkg::ST_REF) && (ref_cnt_reg == REF_LOW_C + 2'h1);
   assign bank_ras = pins.bank ? 2'h1 : 2'h2;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ale_prev_reg <= 1'b1;
         acx_prev_reg <= 1'b1;
         ref_prev_reg <= 1'b1;
      end else if (i_clk_en) begin
         ale_prev_reg <= pins.ale;
         acx_prev_reg <= acx_n;
         ref_prev_reg <= pins.ref_n;
      end
   end

   // New request edge wins over the grant that clears it
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pend_reg <= 1'b0;
      end else if (i_clk_en) begin
         if (ref_prev_reg && !pins.ref_n) begin
            pend_reg <= 1'b1;
         end else if (ref_go && (state_reg == dss_pkg::ST_IDLE
                                 || (state_reg == dss_pkg::ST_TAIL && !acx_rise))) begin
            pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ref_row_reg <= `DSS_REF_ROW_RST;
      end else if (i_clk_en && ref_done) begin
         ref_row_reg <= ref_row_reg + `DSS_ADDR_W'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_reg <= dss_pkg::ST_IDLE;
         req_reg <= '0;
         ras_n_reg <= `DSS_RAS_IDLE;
         cas_n_reg <= 1'b1;
         addr_reg <= '0;
         ready_reg <= 1'b1;
         hold_reg <= 2'h0;
         ref_cnt_reg <= 2'h0;
         early_reg <= 1'b0;
         grant_reg <= 1'b0;
      end else if (i_clk_en) begin
         unique case (state_reg)
            dss_pkg::ST_IDLE: begin
               if (ale_fall) begin
                  req_reg <= '{bank: pins.bank, row: pins.row, col: pins.col};
                  addr_reg <= pins.row;
                  if (!pins.cs_n) begin
                     ras_n_reg <= bank_ras;
                     early_reg <= ~acx_n;
                     hold_reg <= HOLD_LD;
                     state_reg <= dss_pkg::ST_ROW;
                  end
               end else if (ref_go) begin
                  addr_reg <= ref_row_reg;
                  ref_cnt_reg <= 2'h0;
                  grant_reg <= 1'b0;
                  state_reg <= dss_pkg::ST_REF;
               end
            end
            dss_pkg::ST_ROW: begin
               if (hold_reg != 2'h0) begin
                  hold_reg <= hold_reg - 2'h1;
               end
               if (ale_rise && acx_n) begin
                  // Access never came: close the row quietly
                  ras_n_reg <= `DSS_RAS_IDLE;
                  state_reg <= dss_pkg::ST_IDLE;
               end else if (!acx_n && (!early_reg || hold_reg == 2'h0)) begin
                  addr_reg <= req_reg.col;
                  state_reg <= dss_pkg::ST_COL;
               end
            end
            dss_pkg::ST_COL: begin
               cas_n_reg <= 1'b0;
               if (acx_rise) begin
                  ras_n_reg <= `DSS_RAS_IDLE;
                  cas_n_reg <= 1'b1;
                  addr_reg <= req_reg.row;
                  state_reg <= dss_pkg::ST_IDLE;
               end else if (ale_rise) begin
                  ras_n_reg <= `DSS_RAS_IDLE;
                  addr_reg <= pins.row;
                  state_reg <= dss_pkg::ST_TAIL;
               end
            end
            dss_pkg::ST_TAIL: begin
               addr_reg <= pins.row;
               if (acx_rise) begin
                  cas_n_reg <= 1'b1;
                  state_reg <= dss_pkg::ST_IDLE;
               end else if (ref_go) begin
                  // Hidden refresh keeps the column strobe low
                  addr_reg <= ref_row_reg;
                  ref_cnt_reg <= 2'h0;
                  grant_reg <= 1'b0;
                  state_reg <= dss_pkg::ST_REF;
               end
            end
            dss_pkg::ST_REF: begin
               ref_cnt_reg <= ref_cnt_reg + 2'h1;
               if (acx_rise) begin
                  cas_n_reg <= 1'b1;
               end
               if (ref_cnt_reg == 2'h0) begin
                  ras_n_reg <= 2'h0;
               end else if (ref_cnt_reg == REF_LOW_C) begin
                  ras_n_reg <= `DSS_RAS_IDLE;
               end
               if (ale_fall && !pins.cs_n && !grant_reg) begin
                  grant_reg <= 1'b1;
                  ready_reg <= 1'b0;
                  req_reg <= '{bank: pins.bank, row: pins.row, col: pins.col};
                  early_reg <= ~acx_n;
               end
               if (ref_done) begin
                  if (grant_reg) begin
                     ras_n_reg <= req_reg.bank ? 2'h1 : 2'h2;
                     ready_reg <= ~pins.strap;
                     addr_reg <= req_reg.row;
                     hold_reg <= early_reg ? 2'h0 : 2'h1;
                     state_reg <= dss_pkg::ST_GRANT;
                  end else begin
                     addr_reg <= pins.row;
                     // Access ending on this edge must not strand the tail phase
                     state_reg <= (cas_n_reg || acx_rise) ? dss_pkg::ST_IDLE : dss_pkg::ST_TAIL;
                  end
               end
            end
            dss_pkg::ST_GRANT: begin
               ready_reg <= 1'b1;
               grant_reg <= 1'b0;
               if (hold_reg != 2'h0) begin
                  hold_reg <= hold_reg - 2'h1;
               end else if (!acx_n) begin
                  addr_reg <= req_reg.col;
                  state_reg <= dss_pkg::ST_COL;
               end
            end
            default: begin
               state_reg <= dss_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign o_ras_n = ras_n_reg;
   assign o_cas_n = cas_n_reg;
   assign o_mem_addr_out = addr_reg;
   assign o_ready = ready_reg;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst || !i_clk_en);

   localparam int REF_LOW_D = REF_CLKS - 2;

   sequence s_row_open;
      state_reg == dss_pkg::ST_ROW && $past(state_reg) == dss_pkg::ST_IDLE;
   endsequence

   sequence s_grant_start;
      state_reg == dss_pkg::ST_GRANT && $past(state_reg) == dss_pkg::ST_REF;
   endsequence

   property p_row_fall;
      state_reg == dss_pkg::ST_IDLE && ale_fall && !pins.cs_n |=> o_ras_n != 2'h3;
   endproperty
   a_row_fall: assert property (p_row_fall) else $error("row strobe missed");

   property p_row_hold;
      s_row_open ##0 early_reg |-> (o_mem_addr_out == req_reg.row)[*2];
   endproperty
   a_row_hold: assert property (p_row_hold) else $error("row hold short");

   property p_col_after_access;
      state_reg == dss_pkg::ST_ROW && !early_reg && !acx_n && !ale_rise
         |=> state_reg == dss_pkg::ST_COL ##1 !o_cas_n;
   endproperty
   a_col_after_access: assert property (p_col_after_access) else $error("column late");

   property p_tail_end;
      state_reg == dss_pkg::ST_TAIL && acx_rise |=> o_cas_n && state_reg == dss_pkg::ST_IDLE;
   endproperty
   a_tail_end: assert property (p_tail_end) else $error("column strobe stuck");

   property p_access_end;
      state_reg == dss_pkg::ST_COL && acx_rise |=> o_cas_n && o_ras_n == 2'h3;
   endproperty
   a_access_end: assert property (p_access_end) else $error("access rise ignored");

   property p_latch_end;
      state_reg == dss_pkg::ST_COL && ale_rise && !acx_rise
         |=> o_ras_n == 2'h3 && !o_cas_n;
   endproperty
   a_latch_end: assert property (p_latch_end) else $error("latch rise wrong");

   property p_ref_grant;
      state_reg == dss_pkg::ST_IDLE && pend_reg && pins.ale |=> state_reg == dss_pkg::ST_REF;
   endproperty
   a_ref_grant: assert property (p_ref_grant) else $error("refresh not granted");

   property p_ref_width;
      state_reg == dss_pkg::ST_REF && ref_cnt_reg == 2'h0
         |=> o_ras_n == 2'h0 ##REF_LOW_D o_ras_n == 2'h3;
   endproperty
   a_ref_width: assert property (p_ref_width) else $error("refresh width wrong");

   property p_grant_stall;
      state_reg == dss_pkg::ST_REF && ale_fall && !pins.cs_n && !grant_reg |=> !o_ready;
   endproperty
   a_grant_stall: assert property (p_grant_stall) else $error("ready not dropped");

   property p_wait_state;
      s_grant_start and pins.strap |-> !o_ready ##1 o_ready;
   endproperty
   a_wait_state: assert property (p_wait_state) else $error("wait state wrong");

   property p_early_cas;
      s_grant_start and early_reg and !acx_n |-> o_ras_n != 2'h3 ##2 !o_cas_n;
   endproperty
   a_early_cas: assert property (p_early_cas) else $error("early column late");
endmodule
`default_nettype wire

/* File: verif/dss_host_model.sv */
// Host bus control model driving the sequencer pins
`timescale 1ns/1ps
`default_nettype none
module dss_host_model (
   input wire logic i_clk,
   output var dss_pkg::dss_pins_type o_pins
);
   initial o_pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00};

   task automatic step(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic addr(input logic cs_n, input logic bank, input logic [7:0] row,
                       input logic [7:0] col);
      o_pins.cs_n = cs_n;
      o_pins.bank = bank;
      o_pins.row = row;
      o_pins.col = col;
   endtask

   task automatic ale(input logic v);
      o_pins.ale = v;
      step(1);
   endtask

   task automatic acc(input logic rd_n, input logic wr_n);
      o_pins.rd_n = rd_n;
      o_pins.wr_n = wr_n;
      step(1);
   endtask

   // Both strobes on one edge, as if wired together
   task automatic tied(input logic v);
      o_pins.ale = v;
      o_pins.rd_n = v;
      step(1);
   endtask

   task automatic refresh(input logic v);
      o_pins.ref_n = v;
      step(1);
   endtask

   // Idle gap after access rise covers row precharge
   task automatic release_all();
      o_pins.ale = 1'b1;
      o_pins.rd_n = 1'b1;
      o_pins.wr_n = 1'b1;
      step(8);
   endtask
endmodule
`default_nettype wire

/* File: verif/dss_strobe_sequencer_tb.sv */
// Self-checking bench for the DRAM strobe sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dss_map.svh"
module dss_strobe_sequencer_tb;
   localparam int REF = 3;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic clk_en = 1'b1;
   dss_pkg::dss_pins_type pins;
   logic [1:0] o_ras_n;
   logic o_cas_n;
   logic [7:0] o_mem_addr_out;
   logic o_ready;
   int n_fail = 0;
   int checked = 0;
   string nm [4] = '{"ras", "cas", "addr", "ready"};

   initial forever #20 i_clk = ~i_clk;

   dss_host_model host (.i_clk(i_clk), .o_pins(pins));

   dss_strobe_sequencer #(.REF_CLKS(REF)) DUT (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(clk_en),
      .i_ale(pins.ale),
      .i_read_access_strobe_n(pins.rd_n),
      .i_write_access_strobe_n(pins.wr_n),
      .i_chip_select_n(pins.cs_n),
      .i_row_bank_select(pins.bank),
      .i_row_addr_in(pins.row),
      .i_col_addr_in(pins.col),
      .i_refresh_request_n(pins.ref_n),
      .i_wait_state_strap(pins.strap),
      .o_ras_n(o_ras_n),
      .o_cas_n(o_cas_n),
      .o_mem_addr_out(o_mem_addr_out),
      .o_ready(o_ready)
   );

   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [7:0] cur(input int s);
      case (s)
         0: return {6'h00, o_ras_n};
         1: return {7'h00, o_cas_n};
         2: return o_mem_addr_out;
         default: return {7'h00, o_ready};
      endcase
   endfunction

   // Pins pass a synchroniser, so outputs are awaited under a bound
   task automatic await(input int s, input logic [7:0] e);
      int k;
      for (k = 0; k < 14 && cur(s) !== e; k++) @(negedge i_clk);
      check(nm[s], cur(s), e);
   endtask

   task automatic t_lead();
      host.addr(1'b0, 1'b1, 8'hA5, 8'h3C);
      host.ale(1'b0);
      await(0, 8'h01);
      check("addr", o_mem_addr_out, 8'hA5);
      host.step(4);
      check("cas", o_cas_n, 1'b1);
      host.acc(1'b0, 1'b1);
      await(2, 8'h3C);
      await(1, 8'h00);
      host.ale(1'b1);
      await(0, 8'h03);
      host.o_pins.row = 8'h5A;
      await(2, 8'h5A);
      check("cas", o_cas_n, 1'b0);
      host.acc(1'b1, 1'b1);
      await(1, 8'h01);
      host.release_all();
   endtask

   task automatic t_overlap();
      host.addr(1'b0, 1'b0, 8'h0F, 8'hF0);
      host.ale(1'b0);
      await(0, 8'h02);
      host.acc(1'b1, 1'b0);
      await(1, 8'h00);
      host.acc(1'b1, 1'b1);
      await(1, 8'h01);
      check("ras", o_ras_n, 2'h3);
      check("addr", o_mem_addr_out, 8'h0F);
      host.ale(1'b1);
      host.step(6);
      check("ras", o_ras_n, 2'h3);
      host.release_all();
   endtask

   task automatic t_auto();
      host.addr(1'b0, 1'b1, 8'hC3, 8'h96);
      host.tied(1'b0);
      await(0, 8'h01);
      check("addr", o_mem_addr_out, 8'hC3);
      await(2, 8'h96);
      await(1, 8'h00);
      host.ale(1'b1);
      await(0, 8'h03);
      check("cas", o_cas_n, 1'b0);
      host.acc(1'b1, 1'b1);
      await(1, 8'h01);
      host.release_all();
   endtask

   task automatic t_refused();
      host.addr(1'b1, 1'b0, 8'h11, 8'h22);
      host.ale(1'b0);
      host.step(10);
      check("ras", o_ras_n, 2'h3);
      check("cas", o_cas_n, 1'b1);
      host.release_all();
   endtask

   // Frozen enable holds off a latch fall until it is released; then a reset in mid-access
   task automatic t_freeze();
      host.addr(1'b0, 1'b1, 8'h3A, 8'hC5);
      clk_en = 1'b0;
      host.ale(1'b0);
      host.step(8);
      check("ras", o_ras_n, 2'h3);
      clk_en = 1'b1;
      await(0, 8'h01);
      i_sys_rst = 1'b1;
      host.ale(1'b1);
      host.step(2);
      i_sys_rst = 1'b0;
      host.step(4);
      check("ras", o_ras_n, 2'h3);
      check("cas", o_cas_n, 1'b1);
      check("addr", o_mem_addr_out, 8'h00);
      check("ready", o_ready, 1'b1);
      host.release_all();
   endtask

   task automatic t_hidden();
      host.addr(1'b0, 1'b0, 8'h44, 8'h55);
      host.ale(1'b0);
      host.acc(1'b0, 1'b1);
      await(1, 8'h00);
      host.ale(1'b1);
      await(0, 8'h03);
      host.refresh(1'b0);
      await(0, 8'h00);
      check("addr", o_mem_addr_out, `DSS_REF_ROW_RST);
      check("cas", o_cas_n, 1'b0);
      host.step(REF - 2);
      check("ras", o_ras_n, 2'h3);
      host.refresh(1'b1);
      host.acc(1'b1, 1'b1);
      await(1, 8'h01);
      host.release_all();
   endtask

   task automatic t_grant(input logic strap, input logic early);
      host.addr(1'b0, 1'b1, 8'h77, 8'h88);
      host.o_pins.strap = strap;
      if (early) host.acc(1'b0, 1'b1);
      host.refresh(1'b0);
      // Latch falls once the refresh has begun
      host.step(1);
      host.ale(1'b0);
      if (!early) host.acc(1'b0, 1'b1);
      await(3, 8'h00);
      await(0, 8'h01);
      check("ready", o_ready, !strap);
      host.step(1);
      check("ready", o_ready, 1'b1);
      host.step(1);
      check("cas", o_cas_n, !early);
      host.step(1);
      check("cas", o_cas_n, 1'b0);
      host.refresh(1'b1);
      host.ale(1'b1);
      await(0, 8'h03);
      host.acc(1'b1, 1'b1);
      await(1, 8'h01);
      host.release_all();
   endtask

   task automatic finish_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge i_clk);
      n_fail++;
      finish_test();
   end

   initial begin
      repeat (3) @(negedge i_clk);
      i_sys_rst = 1'b0;
      host.step(4);
      check("ras", o_ras_n, 2'h3);
      check("cas", o_cas_n, 1'b1);
      check("addr", o_mem_addr_out, 8'h00);
      check("ready", o_ready, 1'b1);
      t_lead();
      t_overlap();
      t_auto();
      t_refused();
      t_freeze();
      t_hidden();
      for (int i = 0; i < 4; i++) t_grant(i[0], i[1]);
      finish_test();
   end
endmodule
`default_nettype wire
